// ===== cet_pkg.sv
/*
 cet_pkg: register map, field layout, reset values, timing constants and
 carrier types of the CAN fault-state, interrupt-flag and bit-timing block.
 assumes a 100 MHz aclk and a 32-bit AXI4-Lite register port.
*/
package cet_pkg;

	// ==================================================================
	// register map
	localparam logic [7:0]  OFS_FLAGS     = 8'h00;
	localparam logic [7:0]  OFS_ENABLES   = 8'h04;
	localparam logic [7:0]  OFS_COUNTERS  = 8'h08;
	localparam logic [7:0]  OFS_PRESCALE  = 8'h0C;
	localparam logic [7:0]  OFS_SEGMENTS  = 8'h10;
	localparam logic [15:0] FLAG_MASK     = 16'h00EF;
	localparam logic [7:0]  ENABLE_MASK   = 8'hEF;
	localparam logic [15:0] SEGMENTS_MASK = 16'h47FF;
	localparam logic [7:0]  RST_ENABLES   = 8'h00;
	localparam logic [7:0]  RST_PRESCALE  = 8'h00;
	localparam logic [15:0] RST_SEGMENTS  = 16'h0000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ==================================================================
	// field positions
	localparam int BIT_TX_BUS_OFF   = 13;
	localparam int BIT_TX_PASSIVE   = 12;
	localparam int BIT_RX_PASSIVE   = 11;
	localparam int BIT_TX_WARNING   = 10;
	localparam int BIT_RX_WARNING   = 9;
	localparam int BIT_ANY_WARNING  = 8;
	localparam int BIT_INVALID_MSG  = 7;
	localparam int BIT_WAKEUP       = 6;
	localparam int BIT_ERROR        = 5;
	localparam int BIT_FIFO_FULL    = 3;
	localparam int BIT_RX_OVERFLOW  = 2;
	localparam int BIT_RX_BUFFER    = 1;
	localparam int BIT_TX_BUFFER    = 0;
	localparam int BIT_LINE_FILTER  = 14;

	// ==================================================================
	// timing and fault confinement
	localparam int CLK_PERIOD_NS  = 10;
	localparam int WAKE_FILTER_NS = 500;
	localparam logic [6:0] WAKE_FILTER_CYCLES =
		7'((WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] PROC_TIME_TQ  = 4'h2;
	localparam logic [8:0] WARN_LIMIT    = 9'h060;
	localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
	localparam logic [7:0] REC_RETURN    = 8'h7F;
	localparam logic [6:0] RECOVERY_LAST = 7'h7F;

	// ==================================================================
	// carrier types
	typedef struct packed {
		logic [1:0] jump_width;
		logic [5:0] quantum_prescaler;
		logic [2:0] phase2_length;
		logic       phase2_select;
		logic       triple_sample;
		logic [2:0] phase1_length;
		logic [2:0] propagation_length;
	} cet_timing_t;

	typedef struct packed {
		logic invalid_msg;
		logic fifo_almost_full;
		logic rx_overflow;
		logic rx_buffer;
		logic tx_buffer;
	} cet_evt_t;

	typedef struct packed {
		logic tx_error;
		logic tx_ok;
		logic rx_error;
		logic rx_error_major;
		logic rx_ok;
		logic idle_seq;
	} cet_fc_evt_t;

	typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cet_seg_t;

endpackage : cet_pkg

// ===== cet_bit_timing.sv
/*
 cet_bit_timing: quantum divider, bit segment sequencer with jump-width
 resynchronisation, and single or triple sampling of the bus line.
 assumes can_rx is synchronous to aclk and settings change only while idle.
*/
`timescale 1ns/10ps
module cet_bit_timing (
	input  wire logic                 aclk,            // module clock
	input  wire logic                 aresetn,         // sync reset, low
	input  wire cet_pkg::cet_timing_t cfg,             // timing settings
	input  wire logic                 can_rx,          // bus, 1 = recessive
	output logic                      sample_strobe_r, // pulse at sample
	output logic                      sample_bit_r,    // sampled value
	output logic                      bit_start_r      // pulse at sync
);
	logic [6:0]        pre_cnt_r;
	logic              tq_tick;
	cet_pkg::cet_seg_t seg_r;
	logic [3:0]        tq_cnt_r;
	logic [3:0]        ext_r;
	logic              resynced_r;
	logic              rx_prev_r;
	logic [1:0]        hist_r;
	logic [3:0]        jw;
	logic [3:0]        ph1_len;
	logic [3:0]        ph2_len;
	logic [3:0]        seg_len;
	logic              seg_last;
	logic              edge_fall;

	// ==================================================================
	// quantum divider
	assign tq_tick = (pre_cnt_r == {cfg.quantum_prescaler, 1'b1});

	always_ff @(posedge aclk)
	begin
		if (!aresetn || tq_tick)
			pre_cnt_r <= 7'h00;
		else
			pre_cnt_r <= pre_cnt_r + 7'h01;
	end

	// ==================================================================
	// segment lengths
	assign jw      = {2'b00, cfg.jump_width} + 4'h1;
	assign ph1_len = {1'b0, cfg.phase1_length} + 4'h1;

	always_comb
	begin
		if (cfg.phase2_select)
			ph2_len = {1'b0, cfg.phase2_length} + 4'h1;
		else if (ph1_len > cet_pkg::PROC_TIME_TQ)
			ph2_len = ph1_len;
		else
			ph2_len = cet_pkg::PROC_TIME_TQ;
		case (seg_r)
			cet_pkg::SEG_SYNC: seg_len = 4'h1;
			cet_pkg::SEG_PROP: seg_len = {1'b0, cfg.propagation_length} + 4'h1;
			cet_pkg::SEG_PH1:  seg_len = ph1_len + ext_r;
			cet_pkg::SEG_PH2:  seg_len = ph2_len;
			default:           seg_len = 4'h1;
		endcase
	end

	assign seg_last  = (tq_cnt_r == seg_len - 4'h1);
	// one resync per bit, and only on a recessive-to-dominant edge
	assign edge_fall = tq_tick && rx_prev_r && !can_rx && !resynced_r &&
		(seg_r != cet_pkg::SEG_SYNC);

	// ==================================================================
	// segment sequencer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			seg_r      <= cet_pkg::SEG_SYNC;
			tq_cnt_r   <= 4'h0;
			ext_r      <= 4'h0;
			resynced_r <= 1'b0;
		end
		else if (tq_tick)
		begin
			if (edge_fall && seg_r == cet_pkg::SEG_PH2 &&
				(ph2_len - tq_cnt_r) <= jw)
			begin
				// early edge: phase 2 cut short, edge taken as sync quantum
				seg_r      <= cet_pkg::SEG_PROP;
				tq_cnt_r   <= 4'h0;
				resynced_r <= 1'b1;
			end
			else
			begin
				if (edge_fall && seg_r != cet_pkg::SEG_PH2)
				begin
					ext_r      <= jw;
					resynced_r <= 1'b1;
				end
				if (seg_last)
				begin
					tq_cnt_r <= 4'h0;
					case (seg_r)
						cet_pkg::SEG_SYNC: seg_r <= cet_pkg::SEG_PROP;
						cet_pkg::SEG_PROP: seg_r <= cet_pkg::SEG_PH1;
						cet_pkg::SEG_PH1:  seg_r <= cet_pkg::SEG_PH2;
						default:
						begin
							seg_r      <= cet_pkg::SEG_SYNC;
							ext_r      <= 4'h0;
							resynced_r <= 1'b0;
						end
					endcase
				end
				else
					tq_cnt_r <= tq_cnt_r + 4'h1;
			end
		end
	end

	// ==================================================================
	// sampling
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_prev_r       <= 1'b1;
			hist_r          <= 2'h3;
			sample_strobe_r <= 1'b0;
			sample_bit_r    <= 1'b1;
			bit_start_r     <= 1'b0;
		end
		else
		begin
			sample_strobe_r <= tq_tick && seg_last &&
				seg_r == cet_pkg::SEG_PH1;
			bit_start_r     <= tq_tick && seg_last &&
				seg_r == cet_pkg::SEG_PH2;
			if (tq_tick)
			begin
				rx_prev_r <= can_rx;
				hist_r    <= {hist_r[0], can_rx};
			end
			if (tq_tick && seg_last && seg_r == cet_pkg::SEG_PH1)
			begin
				if (cfg.triple_sample)
					sample_bit_r <= (hist_r[1] & hist_r[0]) |
						(hist_r[1] & can_rx) | (hist_r[0] & can_rx);
				else
					sample_bit_r <= can_rx;
			end
		end
	end

	// ==================================================================
	// checks
	// only judged while the prescaler stays at zero across both quanta
	property p_tq_spacing;
		@(posedge aclk) disable iff (!aresetn)
		(tq_tick && cfg.quantum_prescaler == 6'h00) ##1
			(cfg.quantum_prescaler == 6'h00)[*2] |->
			tq_tick && !$past(tq_tick);
	endproperty
	a_tq_spacing: assert property (p_tq_spacing)
		else $error("quantum tick spacing wrong");

	property p_sample_in_ph1;
		@(posedge aclk) disable iff (!aresetn)
		sample_strobe_r |-> $past(seg_r) == cet_pkg::SEG_PH1 &&
			seg_r == cet_pkg::SEG_PH2;
	endproperty
	a_sample_in_ph1: assert property (p_sample_in_ph1)
		else $error("sample point not at end of phase 1");

endmodule : cet_bit_timing

// ===== cet_top.sv
/*
 cet_top: AXI4-Lite register file with fault-state status, clear-only
 event flags and enables, error counters, wake-up detection and bit timing.
 assumes event inputs are one-cycle pulses synchronous to aclk.
*/
`timescale 1ns/10ps
module cet_top (
	input  wire logic                 aclk,         // 100 MHz clock
	input  wire logic                 aresetn,      // sync reset, low
	input  wire logic [7:0]           awaddr,       // write address
	input  wire logic                 awvalid,      // write address valid
	output logic                      awready,      // write address ready
	input  wire logic [31:0]          wdata,        // write data
	input  wire logic [3:0]           wstrb,        // write byte lanes
	input  wire logic                 wvalid,       // write data valid
	output logic                      wready,       // write data ready
	output logic [1:0]                bresp,        // write response
	output logic                      bvalid,       // write response valid
	input  wire logic                 bready,       // write response ready
	input  wire logic [7:0]           araddr,       // read address
	input  wire logic                 arvalid,      // read address valid
	output logic                      arready,      // read address ready
	output logic [31:0]               rdata,        // read data
	output logic [1:0]                rresp,        // read response
	output logic                      rvalid,       // read data valid
	input  wire logic                 rready,       // read data ready
	input  wire logic                 can_rx,       // bus line
	input  wire cet_pkg::cet_evt_t    evt,          // message events
	input  wire cet_pkg::cet_fc_evt_t fc_evt,       // confinement events
	output logic                      irq_req_r,    // enabled flag pending
	output logic                      tx_bus_off_r, // transmitter off
	output logic                      sample_strobe, // sample point pulse
	output logic                      sample_bit,    // sampled bus value
	output logic                      bit_start      // bit start pulse
);
	logic        aw_got_r;
	logic        w_got_r;
	logic [7:0]  wr_addr_r;
	logic [31:0] wr_data_r;
	logic [3:0]  wr_strb_r;
	logic        wr_go;
	logic [31:0] rd_data;
	logic        rd_ok;
	logic [15:0] flags_r;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic [15:0] stat_r;
	logic [15:0] stat_d_r;
	logic [15:0] stat_nxt;
	logic [7:0]  enables_r;
	logic [7:0]  prescale_r;
	logic [15:0] segments_r;
	logic [8:0]  tec_r;
	logic [7:0]  rec_r;
	logic [8:0]  tec_nxt;
	logic [8:0]  rec_sum;
	logic [7:0]  rec_nxt;
	logic [7:0]  tec_view;
	logic [6:0]  recov_cnt_r;
	logic        rx_d_r;
	logic [6:0]  low_cnt_r;
	logic        wake_set;
	cet_pkg::cet_timing_t timing;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==================================================================
	// write channels: address and data taken in either order
	assign wr_go = aw_got_r && w_got_r && !bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			bvalid    <= 1'b0;
			bresp     <= cet_pkg::RESP_OKAY;
			wr_addr_r <= 8'h00;
			wr_data_r <= 32'h0000_0000;
			wr_strb_r <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_got_r  <= 1'b1;
				awready   <= 1'b0;
				wr_addr_r <= {awaddr[7:2], 2'b00};
			end
			if (wvalid && wready)
			begin
				w_got_r   <= 1'b1;
				wready    <= 1'b0;
				wr_data_r <= wdata;
				wr_strb_r <= wstrb;
			end
			if (wr_go)
			begin
				bvalid <= 1'b1;
				case (wr_addr_r)
					cet_pkg::OFS_FLAGS, cet_pkg::OFS_ENABLES,
					cet_pkg::OFS_COUNTERS, cet_pkg::OFS_PRESCALE,
					cet_pkg::OFS_SEGMENTS: bresp <= cet_pkg::RESP_OKAY;
					default:               bresp <= cet_pkg::RESP_SLVERR;
				endcase
			end
			if (bvalid && bready)
			begin
				bvalid   <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				awready  <= 1'b1;
				wready   <= 1'b1;
			end
		end
	end

	// ==================================================================
	// read channel
	always_comb
	begin
		rd_ok = 1'b1;
		case ({araddr[7:2], 2'b00})
			cet_pkg::OFS_FLAGS:    rd_data = {16'h0000, stat_r | flags_r};
			cet_pkg::OFS_ENABLES:  rd_data = {24'h00_0000, enables_r};
			cet_pkg::OFS_COUNTERS: rd_data = {16'h0000, tec_view, rec_r};
			cet_pkg::OFS_PRESCALE: rd_data = {24'h00_0000, prescale_r};
			cet_pkg::OFS_SEGMENTS: rd_data = {16'h0000, segments_r};
			default:
			begin
				rd_data = 32'h0000_0000;
				rd_ok   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= cet_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_data;
			rresp   <= rd_ok ? cet_pkg::RESP_OKAY : cet_pkg::RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// ==================================================================
	// configuration registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enables_r  <= cet_pkg::RST_ENABLES;
			prescale_r <= cet_pkg::RST_PRESCALE;
			segments_r <= cet_pkg::RST_SEGMENTS;
		end
		else if (wr_go)
		begin
			if (wr_addr_r == cet_pkg::OFS_ENABLES && wr_strb_r[0])
				enables_r <= wr_data_r[7:0] & cet_pkg::ENABLE_MASK;
			if (wr_addr_r == cet_pkg::OFS_PRESCALE && wr_strb_r[0])
				prescale_r <= wr_data_r[7:0];
			if (wr_addr_r == cet_pkg::OFS_SEGMENTS)
			begin
				if (wr_strb_r[0])
					segments_r[7:0] <= wr_data_r[7:0];
				if (wr_strb_r[1])
					segments_r[15:8] <= wr_data_r[15:8] &
						cet_pkg::SEGMENTS_MASK[15:8];
			end
		end
	end

	assign timing = {prescale_r, segments_r[10:0]};

	// ==================================================================
	// wake-up detection; the filter rejects glitches shorter than its time
	assign wake_set = segments_r[cet_pkg::BIT_LINE_FILTER] ?
		(!can_rx && low_cnt_r == cet_pkg::WAKE_FILTER_CYCLES - 7'h01) :
		(rx_d_r && !can_rx);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_d_r    <= 1'b1;
			low_cnt_r <= 7'h00;
		end
		else
		begin
			rx_d_r <= can_rx;
			if (can_rx)
				low_cnt_r <= 7'h00;
			else if (low_cnt_r != cet_pkg::WAKE_FILTER_CYCLES)
				low_cnt_r <= low_cnt_r + 7'h01;
		end
	end

	// ==================================================================
	// fault confinement counters
	always_comb
	begin
		tec_nxt = tec_r;
		if (fc_evt.tx_error)
			tec_nxt = tec_r + 9'h008;
		else if (fc_evt.tx_ok && tec_r != 9'h000)
			tec_nxt = tec_r - 9'h001;
		rec_sum = {1'b0, rec_r};
		if (fc_evt.rx_error_major)
			rec_sum = rec_sum + 9'h008;
		else if (fc_evt.rx_error)
			rec_sum = rec_sum + 9'h001;
		else if (fc_evt.rx_ok && rec_sum >= cet_pkg::PASSIVE_LIMIT)
			rec_sum = {1'b0, cet_pkg::REC_RETURN};
		else if (fc_evt.rx_ok && rec_sum != 9'h000)
			rec_sum = rec_sum - 9'h001;
		rec_nxt = rec_sum[8] ? 8'hFF : rec_sum[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tec_r       <= 9'h000;
			rec_r       <= 8'h00;
			recov_cnt_r <= 7'h00;
		end
		else if (tec_r[8])
		begin
			// bus-off: leave only after enough idle sequences
			if (fc_evt.idle_seq)
			begin
				recov_cnt_r <= recov_cnt_r + 7'h01;
				if (recov_cnt_r == cet_pkg::RECOVERY_LAST)
				begin
					tec_r <= 9'h000;
					rec_r <= 8'h00;
				end
			end
		end
		else
		begin
			tec_r       <= tec_nxt;
			rec_r       <= rec_nxt;
			recov_cnt_r <= 7'h00;
		end
	end

	assign tec_view = tec_r[8] ? 8'hFF : tec_r[7:0];

	// ==================================================================
	// fault-state status
	always_comb
	begin
		stat_nxt = 16'h0000;
		stat_nxt[cet_pkg::BIT_TX_BUS_OFF] = tec_r[8];
		stat_nxt[cet_pkg::BIT_TX_PASSIVE] = !tec_r[8] &&
			tec_r >= cet_pkg::PASSIVE_LIMIT;
		stat_nxt[cet_pkg::BIT_RX_PASSIVE] =
			{1'b0, rec_r} >= cet_pkg::PASSIVE_LIMIT;
		stat_nxt[cet_pkg::BIT_TX_WARNING] = tec_r >= cet_pkg::WARN_LIMIT &&
			tec_r < cet_pkg::PASSIVE_LIMIT;
		stat_nxt[cet_pkg::BIT_RX_WARNING] =
			{1'b0, rec_r} >= cet_pkg::WARN_LIMIT &&
			{1'b0, rec_r} < cet_pkg::PASSIVE_LIMIT;
		stat_nxt[cet_pkg::BIT_ANY_WARNING] =
			stat_nxt[cet_pkg::BIT_TX_WARNING] |
			stat_nxt[cet_pkg::BIT_RX_WARNING];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stat_r       <= 16'h0000;
			stat_d_r     <= 16'h0000;
			tx_bus_off_r <= 1'b0;
		end
		else
		begin
			stat_r       <= stat_nxt;
			stat_d_r     <= stat_r;
			tx_bus_off_r <= stat_nxt[cet_pkg::BIT_TX_BUS_OFF];
		end
	end

	// ==================================================================
	// clear-only flags: software writes 0 to clear; a set in the same
	// cycle wins so no event is lost
	always_comb
	begin
		flag_set = 16'h0000;
		flag_set[cet_pkg::BIT_INVALID_MSG] = evt.invalid_msg;
		flag_set[cet_pkg::BIT_WAKEUP]      = wake_set;
		flag_set[cet_pkg::BIT_ERROR]       = |(stat_r & ~stat_d_r);
		flag_set[cet_pkg::BIT_FIFO_FULL]   = evt.fifo_almost_full;
		flag_set[cet_pkg::BIT_RX_OVERFLOW] = evt.rx_overflow;
		flag_set[cet_pkg::BIT_RX_BUFFER]   = evt.rx_buffer;
		flag_set[cet_pkg::BIT_TX_BUFFER]   = evt.tx_buffer;
		flag_clr = 16'h0000;
		if (wr_go && wr_addr_r == cet_pkg::OFS_FLAGS && wr_strb_r[0])
			flag_clr = {8'h00, ~wr_data_r[7:0]};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flags_r   <= 16'h0000;
			irq_req_r <= 1'b0;
		end
		else
		begin
			flags_r   <= ((flags_r & ~flag_clr) | flag_set) &
				cet_pkg::FLAG_MASK;
			irq_req_r <= |(flags_r[7:0] & enables_r);
		end
	end

	// ==================================================================
	// bit timing engine
	cet_bit_timing u_timing (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.cfg             (timing),
		.can_rx          (can_rx),
		.sample_strobe_r (sample_strobe),
		.sample_bit_r    (sample_bit),
		.bit_start_r     (bit_start)
	);

	// ==================================================================
	// checks
	property p_bus_off;
		tec_r[8] |=> stat_r[cet_pkg::BIT_TX_BUS_OFF] && tx_bus_off_r;
	endproperty
	a_bus_off: assert property (p_bus_off)
		else $error("bus-off status not shown");

	property p_tx_passive;
		(tec_r >= cet_pkg::PASSIVE_LIMIT && !tec_r[8]) |=>
			stat_r[cet_pkg::BIT_TX_PASSIVE] && !stat_r[cet_pkg::BIT_TX_BUS_OFF];
	endproperty
	a_tx_passive: assert property (p_tx_passive)
		else $error("transmit passive status wrong");

	property p_rx_passive;
		rec_r[7] |=> stat_r[cet_pkg::BIT_RX_PASSIVE] &&
			!stat_r[cet_pkg::BIT_RX_WARNING];
	endproperty
	a_rx_passive: assert property (p_rx_passive)
		else $error("receive passive status wrong");

	property p_any_warning;
		stat_r[cet_pkg::BIT_ANY_WARNING] == (stat_r[cet_pkg::BIT_TX_WARNING] |
			stat_r[cet_pkg::BIT_RX_WARNING]);
	endproperty
	a_any_warning: assert property (p_any_warning)
		else $error("combined warning disagrees");

	property p_error_flag;
		$rose(stat_r[cet_pkg::BIT_RX_WARNING]) |=>
			flags_r[cet_pkg::BIT_ERROR];
	endproperty
	a_error_flag: assert property (p_error_flag)
		else $error("error flag not set on state change");

	property p_set_wins;
		evt.invalid_msg |=> flags_r[cet_pkg::BIT_INVALID_MSG] ##1
			flags_r[cet_pkg::BIT_INVALID_MSG] || $past(wr_go);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("invalid message event lost");

	property p_enable_gate;
		(enables_r == 8'h00)[*2] |-> !irq_req_r;
	endproperty
	a_enable_gate: assert property (p_enable_gate)
		else $error("request without enable");

	property p_counter_read;
		(arvalid && arready && {araddr[7:2], 2'b00} == cet_pkg::OFS_COUNTERS)
			|=> rvalid && rdata[15:0] == {$past(tec_view), $past(rec_r)};
	endproperty
	a_counter_read: assert property (p_counter_read)
		else $error("counter register read wrong");

	property p_wake_unfiltered;
		(!segments_r[cet_pkg::BIT_LINE_FILTER] && rx_d_r && !can_rx) |=>
			flags_r[cet_pkg::BIT_WAKEUP];
	endproperty
	a_wake_unfiltered: assert property (p_wake_unfiltered)
		else $error("wake-up edge not flagged");

endmodule : cet_top

// ===== cet_bus_model.sv
/*
 cet_bus_model: far side of the CAN line, pulls it dominant on demand.
 assumes a pull-up: the line reads recessive while nobody drives it.
*/
`timescale 1ns/10ps
module cet_bus_model (
	input  wire logic       aclk,    // module clock
	input  wire logic       aresetn, // sync reset, low
	input  wire logic       go,      // start a dominant pulse
	input  wire logic [6:0] len,     // pulse length in cycles
	output logic            can_rx   // bus line, 1 = recessive
);
	logic [6:0] left_r;
	// ========
	// dominant pulse
	always_ff @(posedge aclk)
		if (!aresetn)
			left_r <= 7'h00;
		else if (go)
			left_r <= len;
		else if (left_r != 7'h00)
			left_r <= left_r - 7'h01;
	assign can_rx = (left_r == 7'h00);
endmodule : cet_bus_model

// ===== cet_top_tb.sv
/*
 cet_top_tb: register reads checked against a queue of expected words.
 assumes cet_bus_model on the line and offsets 00..10.
*/
`timescale 1ns/10ps
module cet_top_tb;
	// ========
	// signals
	logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [6:0]  len = 7'h00;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, arready, bvalid, rvalid, can_rx;
	logic        irq_req_r, tx_bus_off_r, sample_strobe, sample_bit;
	logic        bit_start;
	cet_pkg::cet_evt_t    evt = '0;
	cet_pkg::cet_fc_evt_t fc_evt = '0;
	logic [33:0] exp_q[$];
	logic [15:0] seg[2] = '{16'h0288, 16'h0248};
	int          bit_clk[2] = '{28, 24};
	int          mismatches = 0, compares = 0, cyc = 0, seed = 95122, t0;

	always #5 aclk = ~aclk;
	// answers are taken at once, so bready and rready stay high
	cet_top cet_top_i (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.awaddr        (awaddr),
		.awvalid       (awvalid),
		.awready       (awready),
		.wdata         (wdata),
		.wstrb         (4'hF),
		.wvalid        (wvalid),
		.wready        (wready),
		.bresp         (bresp),
		.bvalid        (bvalid),
		.bready        (1'b1),
		.araddr        (araddr),
		.arvalid       (arvalid),
		.arready       (arready),
		.rdata         (rdata),
		.rresp         (rresp),
		.rvalid        (rvalid),
		.rready        (1'b1),
		.can_rx        (can_rx),
		.evt           (evt),
		.fc_evt        (fc_evt),
		.irq_req_r     (irq_req_r),
		.tx_bus_off_r  (tx_bus_off_r),
		.sample_strobe (sample_strobe),
		.sample_bit    (sample_bit),
		.bit_start     (bit_start)
	);
	cet_bus_model cet_bus_model_i (
		.aclk    (aclk),
		.aresetn (aresetn),
		.go      (go),
		.len     (len),
		.can_rx  (can_rx)
	);

	// ========
	// tasks
	task test_done;
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		chk({32'h0, (a <= cet_pkg::OFS_SEGMENTS) ? cet_pkg::RESP_OKAY :
			cet_pkg::RESP_SLVERR}, {32'h0, bresp});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
	endtask : rd
	task automatic conf(input cet_pkg::cet_fc_evt_t e, input int n);
		repeat (n)
		begin
			fc_evt <= e;
			@(posedge aclk);
			fc_evt <= '0;
			@(posedge aclk);
		end
		// the error flag trails the status bits by one more edge
		@(posedge aclk);
	endtask : conf
	task automatic dom(input logic [6:0] n);
		go <= 1'b1;
		len <= n;
		@(posedge aclk);
		go <= 1'b0;
		repeat (n + 3) @(posedge aclk);
	endtask : dom

	// ========
	// read monitor and timeout
	always @(posedge aclk)
	begin
		cyc++;
		if (rvalid === 1'b1)
			chk(exp_q.pop_front(), {rresp, rdata});
		if (cyc == 5000)
		begin
			mismatches++;
			test_done;
		end
	end

	// ========
	// sequence
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int a = 0; a < 20; a += 4)
			rd(8'(a), 34'h0);
		rd(8'h14, {cet_pkg::RESP_SLVERR, 32'h0});
		v = $random(seed);
		wr(8'h14, v);
		wr(8'h04, v);
		wr(8'h08, v);
		rd(8'h04, {26'h0, v[7:0] & cet_pkg::ENABLE_MASK});
		rd(8'h08, 34'h0);
		evt <= 5'h1F;
		@(posedge aclk);
		evt <= '0;
		rd(8'h00, 34'h8F);
		chk({33'h0, |(v[7:0] & 8'h8F)}, {33'h0, irq_req_r});
		wr(8'h00, 32'hFF0F);
		rd(8'h00, 34'h0F);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'hFF);
		rd(8'h00, 34'h0);
		wr(8'h0C, 32'h01);
		// one bit is sync + prop + phase 1 + phase 2 quanta of 4 clocks
		for (int i = 0; i < 2; i++)
		begin
			wr(8'h10, {16'h0, seg[i]});
			repeat (2) @(posedge bit_start);
			t0 = cyc;
			@(posedge sample_strobe);
			chk(34'd16, 34'(cyc - t0));
			@(posedge bit_start);
			chk(34'(bit_clk[i]), 34'(cyc - t0));
			chk(34'h1, {33'h0, sample_bit});
		end
		dom(7'd3);
		rd(8'h00, 34'h40);
		wr(8'h00, 32'h0);
		wr(8'h10, 32'h4208);
		dom(7'd10);
		rd(8'h00, 34'h0);
		dom(7'd60);
		rd(8'h00, 34'h40);
		wr(8'h00, 32'h0);
		conf(6'h04, 12);
		rd(8'h00, 34'h320);
		conf(6'h04, 4);
		rd(8'h00, 34'h820);
		rd(8'h08, 34'h80);
		conf(6'h02, 1);
		rd(8'h08, 34'h7F);
		wr(8'h00, 32'h0);
		rd(8'h00, 34'h300);
		conf(6'h20, 12);
		rd(8'h00, 34'h720);
		rd(8'h08, 34'h607F);
		conf(6'h20, 4);
		rd(8'h00, 34'h1320);
		conf(6'h20, 16);
		rd(8'h00, 34'h2320);
		rd(8'h08, 34'hFF7F);
		chk(34'h1, {33'h0, tx_bus_off_r});
		conf(6'h01, 128);
		rd(8'h00, 34'h20);
		rd(8'h08, 34'h0);
		test_done;
	end
endmodule : cet_top_tb
